// ---- shared/csrs_pkg.sv ----
// Constants, types and the state layout of the CPU system register set
// What this block does
// - Exception or maskable interrupt saves PC, status
// - Non-maskable interrupt saves PC, status separately
// - NMI code goes to cause upper half
// - Exception/interrupt code goes to cause lower half
// - Access by number; 0-5 used, rest reserved
// - Status flags placed at bits 7 to 0
// - Upper status bits zero; reset value 20h
// - NMI sets servicing flag, blocks nested interrupts
// - Exception sets flag; interrupts stay acknowledgeable
// - Disable flag masks maskable interrupts, set on maskable acknowledge
// - Saturation flag sticky; only software write clears
// - Carry flag follows carry or borrow
// - Overflow flag follows signed range overflow
// - Sign flag set on negative result
// - Zero flag set on zero result
// - Positive overflow sets saturation, overflow; maximum, sign clear
// - Negative overflow: saturation, overflow, sign set, minimum
// - In range: result kept, overflow clear, saturation kept
// - Result from overflow and sign; overflow sets saturation
package csrs_pkg;

  // Widths
  localparam int unsigned CSRS_DW    = 32;  // Register width
  localparam int unsigned CSRS_NUMW  = 5;   // Register number width
  localparam int unsigned CSRS_CODEW = 16;  // Exception code width
  localparam int unsigned CSRS_FLAGW = 8;   // Implemented status bits

  // System register numbers
  localparam logic [4:0] CSRS_IDX_EXC_PC = 5'h00;  // exception_saved_pc
  localparam logic [4:0] CSRS_IDX_EXC_ST = 5'h01;  // exception_saved_status
  localparam logic [4:0] CSRS_IDX_NMI_PC = 5'h02;  // nmi_saved_pc
  localparam logic [4:0] CSRS_IDX_NMI_ST = 5'h03;  // nmi_saved_status
  localparam logic [4:0] CSRS_IDX_CAUSE  = 5'h04;  // interrupt_cause
  localparam logic [4:0] CSRS_IDX_PSW    = 5'h05;  // program_status_word

  // Status flag positions
  localparam int unsigned CSRS_BIT_NMI   = 7;  // nmi_servicing_flag
  localparam int unsigned CSRS_BIT_EXC   = 6;  // exception_processing_flag
  localparam int unsigned CSRS_BIT_ID    = 5;  // interrupt_disable_flag
  localparam int unsigned CSRS_BIT_SAT   = 4;  // saturation_flag
  localparam int unsigned CSRS_BIT_CARRY = 3;  // carry_flag
  localparam int unsigned CSRS_BIT_OVF   = 2;  // overflow_flag
  localparam int unsigned CSRS_BIT_S     = 1;  // Sign flag
  localparam int unsigned CSRS_BIT_Z     = 0;  // Zero flag

  // Cause register halves
  localparam int unsigned CSRS_CAUSE_NMI_LSB = 16;  // nmi_cause_code
  localparam int unsigned CSRS_CAUSE_EXC_LSB = 0;   // exception_cause_code

  // Reset and saturation values
  localparam logic [31:0] CSRS_PSW_RESET = 32'h0000_0020;
  localparam logic [7:0]  CSRS_FLAGS_RESET = CSRS_PSW_RESET[7:0];
  localparam logic [31:0] CSRS_SAT_MAX = 32'h7fff_ffff;  // Largest positive
  localparam logic [31:0] CSRS_SAT_MIN = 32'h8000_0000;  // Most negative
  localparam logic [31:0] CSRS_ZERO    = 32'h0000_0000;  // Read filler

  // Event taken in a cycle, highest priority first
  typedef enum logic [1:0] {
    CSRS_EV_NONE,
    CSRS_EV_NMI,
    CSRS_EV_EXC,
    CSRS_EV_MI
  } csrs_event_t;

  // Whole state of the register set
  typedef struct packed {
    logic [31:0] exc_pc;      // exception_saved_pc
    logic [31:0] exc_st;      // exception_saved_status
    logic [31:0] nmi_pc;      // nmi_saved_pc
    logic [31:0] nmi_st;      // nmi_saved_status
    logic [31:0] cause;       // interrupt_cause
    logic [7:0]  flags;       // Implemented status bits
    logic [31:0] rdata;       // Last read value
    logic        nmi_ack;     // NMI acknowledge pulse
    logic        exc_ack;     // Exception acknowledge pulse
    logic        mi_ack;      // Maskable acknowledge pulse
    logic [31:0] sat_result;  // Last saturating result
    logic        sat_valid;   // Saturating result pulse
  } csrs_state_t;

  localparam csrs_state_t CSRS_STATE_RESET = '{
    flags:   CSRS_FLAGS_RESET,
    default: '0
  };

endpackage

// ---- rtl/csrs_sat.sv ----
// Saturating add/subtract datapath with flag outputs
`timescale 1ns/1ps

module csrs_sat (
  input  wire logic [csrs_pkg::CSRS_DW-1:0] a_in,         // Operand A
  input  wire logic [csrs_pkg::CSRS_DW-1:0] b_in,         // Operand B
  input  wire logic                         sub_in,       // 1 = A minus B
  output logic      [csrs_pkg::CSRS_DW-1:0] result_out,   // Clamped result
  output logic                              ovf_out,      // Overflow flag
  output logic                              neg_out,      // Sign flag
  output logic                              zero_out,     // Zero flag
  output logic                              carry_out     // Carry/borrow
);
  import csrs_pkg::*;

  logic [CSRS_DW:0] ext_sum;   // Sign-extended exact result
  logic [CSRS_DW:0] uns_sum;   // Zero-extended result for carry
  logic [CSRS_DW:0] ext_b;     // Sign-extended B
  logic             true_neg;  // Sign of the exact result

  // Wide arithmetic so neither overflow nor carry is lost
  always_comb begin
    ext_b = {b_in[CSRS_DW-1], b_in};
    if (sub_in) begin
      ext_sum = {a_in[CSRS_DW-1], a_in} - ext_b;
      uns_sum = {1'b0, a_in} - {1'b0, b_in};
    end else begin
      ext_sum = {a_in[CSRS_DW-1], a_in} + ext_b;
      uns_sum = {1'b0, a_in} + {1'b0, b_in};
    end
  end

  // Overflow and sign first, then the result is chosen from them alone; zero flag last
  always_comb begin
    carry_out = uns_sum[CSRS_DW];
    ovf_out   = ext_sum[CSRS_DW] ^ ext_sum[CSRS_DW-1];
    // Exact sign wins over the wrapped bit when out of range
    true_neg  = ext_sum[CSRS_DW];
    neg_out   = ovf_out ? true_neg : ext_sum[CSRS_DW-1];
    if (ovf_out && !neg_out) begin
      result_out = CSRS_SAT_MAX;
    end else if (ovf_out) begin
      result_out = CSRS_SAT_MIN;
    end else begin
      result_out = ext_sum[CSRS_DW-1:0];
    end
    zero_out = (result_out == CSRS_ZERO);
  end

endmodule

// ---- rtl/csrs_regs.sv ----
// CPU system register set: save pairs, cause and status word
`timescale 1ns/1ps

module csrs_regs (
  input  wire logic                           clk_in,        // CPU clock
  input  wire logic                           rst_in,        // Sync reset
  input  wire logic [csrs_pkg::CSRS_DW-1:0]   pc_in,         // Current PC
  // Software access by register number
  input  wire logic [csrs_pkg::CSRS_NUMW-1:0] sysreg_num_in, // Reg number
  input  wire logic                           load_system_register_instr_in,
                                                             // Write strobe
  input  wire logic                           store_system_register_instr_in,
                                                             // Read strobe
  input  wire logic [csrs_pkg::CSRS_DW-1:0]   wdata_in,      // Write data
  output logic      [csrs_pkg::CSRS_DW-1:0]   rdata_out,     // Read data
  // Interrupt and exception requests
  input  wire logic                           nmi_req_in,    // NMI request
  input  wire logic                           exc_req_in,    // Exception req
  input  wire logic                           mi_req_in,     // Maskable req
  input  wire logic [csrs_pkg::CSRS_CODEW-1:0] nmi_code_in,  // NMI code
  input  wire logic [csrs_pkg::CSRS_CODEW-1:0] exc_code_in,  // Exception code
  input  wire logic [csrs_pkg::CSRS_CODEW-1:0] mi_code_in,   // Maskable code
  output logic                                nmi_ack_out,   // NMI taken
  output logic                                exc_ack_out,   // Exc taken
  output logic                                mi_ack_out,    // Maskable taken
  // Ordinary arithmetic flag update
  input  wire logic                           flags_we_in,   // Update flags
  input  wire logic [csrs_pkg::CSRS_DW-1:0]   alu_result_in, // ALU result
  input  wire logic                           alu_carry_in,  // Carry/borrow
  input  wire logic                           alu_ovf_in,    // Signed ovf
  // Saturating operation
  input  wire logic                           sat_op_in,     // Start sat op
  input  wire logic                           sat_sub_in,    // 1 = subtract
  input  wire logic [csrs_pkg::CSRS_DW-1:0]   sat_a_in,      // Operand A
  input  wire logic [csrs_pkg::CSRS_DW-1:0]   sat_b_in,      // Operand B
  output logic      [csrs_pkg::CSRS_DW-1:0]   sat_result_out,// Sat result
  output logic                                sat_valid_out, // Result pulse
  // Status word for the rest of the CPU
  output logic      [csrs_pkg::CSRS_DW-1:0]   psw_out        // Status word
);
  import csrs_pkg::*;

  csrs_state_t s;       // Registered state
  csrs_state_t next_s;  // Next state

  // Saturation datapath outputs
  logic [31:0] sat_res;   // Clamped result
  logic        sat_ovf;   // Overflow of exact result
  logic        sat_neg;   // Sign of exact result
  logic        sat_zero;  // Clamped result is zero
  logic        sat_carry; // Unsigned carry or borrow

  // Arbitration helpers
  csrs_event_t ev;        // Event taken this cycle
  logic [31:0] cur_psw;   // Status word before this cycle

  // Register number match, used for both read and write decode
  function automatic logic hit(input logic [4:0] num,
                               input logic [4:0] idx);
    hit = (num == idx);
  endfunction

  // Widen the stored flags to a full word, upper bits zero
  function automatic logic [31:0] psw_word(input logic [7:0] f);
    psw_word = {{(CSRS_DW-CSRS_FLAGW){1'b0}}, f};
  endfunction

  // Saturating add/subtract, purely combinational
  csrs_sat u_sat (
    .a_in       (sat_a_in),
    .b_in       (sat_b_in),
    .sub_in     (sat_sub_in),
    .result_out (sat_res),
    .ovf_out    (sat_ovf),
    .neg_out    (sat_neg),
    .zero_out   (sat_zero),
    .carry_out  (sat_carry)
  );

  // Pick at most one event; requests are levels held until acked
  always_comb begin
    cur_psw = psw_word(s.flags);
    if (nmi_req_in && !s.flags[CSRS_BIT_NMI]) begin
      ev = CSRS_EV_NMI;
    end else if (exc_req_in) begin
      ev = CSRS_EV_EXC;
    end else if (mi_req_in && !s.flags[CSRS_BIT_ID]
                 && !s.flags[CSRS_BIT_NMI]) begin
      // Exception-processing flag does not gate this
      ev = CSRS_EV_MI;
    end else begin
      ev = CSRS_EV_NONE;
    end
  end

  // Next-state logic; later stages override earlier ones
  always_comb begin
    next_s = s;
    // Pulses last one cycle
    next_s.nmi_ack   = 1'b0;
    next_s.exc_ack   = 1'b0;
    next_s.mi_ack    = 1'b0;
    next_s.sat_valid = 1'b0;

    // Stage 1: arithmetic flags
    if (sat_op_in) begin
      // Saturating op owns the flags this cycle
      next_s.flags[CSRS_BIT_CARRY] = sat_carry;
      next_s.flags[CSRS_BIT_OVF]   = sat_ovf;
      next_s.flags[CSRS_BIT_S]     = sat_neg;
      next_s.flags[CSRS_BIT_Z]     = sat_zero;
      // Sticky: set here on overflow, never cleared here; only a status word write clears it
      if (sat_ovf) begin
        next_s.flags[CSRS_BIT_SAT] = 1'b1;
      end
      next_s.sat_result = sat_res;
      next_s.sat_valid  = 1'b1;
    end else if (flags_we_in) begin
      // Plain ALU op leaves saturation untouched
      next_s.flags[CSRS_BIT_CARRY] = alu_carry_in;
      next_s.flags[CSRS_BIT_OVF]   = alu_ovf_in;
      next_s.flags[CSRS_BIT_S]     = alu_result_in[CSRS_DW-1];
      next_s.flags[CSRS_BIT_Z]     = (alu_result_in == CSRS_ZERO);
    end

    // Stage 2: software write by register number
    if (load_system_register_instr_in) begin
      if (hit(sysreg_num_in, CSRS_IDX_EXC_PC)) begin
        next_s.exc_pc = wdata_in;
      end
      if (hit(sysreg_num_in, CSRS_IDX_EXC_ST)) begin
        next_s.exc_st = wdata_in;
      end
      if (hit(sysreg_num_in, CSRS_IDX_NMI_PC)) begin
        next_s.nmi_pc = wdata_in;
      end
      if (hit(sysreg_num_in, CSRS_IDX_NMI_ST)) begin
        next_s.nmi_st = wdata_in;
      end
      if (hit(sysreg_num_in, CSRS_IDX_CAUSE)) begin
        next_s.cause = wdata_in;
      end
      if (hit(sysreg_num_in, CSRS_IDX_PSW)) begin
        // All flags at once, the only way to clear saturation
        next_s.flags = wdata_in[CSRS_FLAGW-1:0];
      end
      // Numbers 6 to 31 fall through with no effect
    end

    // Stage 3: hardware events win over a same-cycle write
    unique case (ev)
      CSRS_EV_NMI: begin
        next_s.nmi_pc = pc_in;
        next_s.nmi_st = cur_psw;
        next_s.cause[CSRS_CAUSE_NMI_LSB +: CSRS_CODEW] =
          nmi_code_in;
        next_s.flags[CSRS_BIT_NMI] = 1'b1;
        next_s.nmi_ack = 1'b1;
      end
      CSRS_EV_EXC: begin
        next_s.exc_pc = pc_in;
        next_s.exc_st = cur_psw;
        next_s.cause[CSRS_CAUSE_EXC_LSB +: CSRS_CODEW] =
          exc_code_in;
        next_s.flags[CSRS_BIT_EXC] = 1'b1;
        next_s.exc_ack = 1'b1;
      end
      CSRS_EV_MI: begin
        next_s.exc_pc = pc_in;
        next_s.exc_st = cur_psw;
        next_s.cause[CSRS_CAUSE_EXC_LSB +: CSRS_CODEW] =
          mi_code_in;
        next_s.flags[CSRS_BIT_ID] = 1'b1;
        next_s.mi_ack = 1'b1;
      end
      CSRS_EV_NONE: begin
        // Nothing taken
      end
    endcase

    // Read returns the value before this cycle's updates
    if (store_system_register_instr_in) begin
      if (hit(sysreg_num_in, CSRS_IDX_EXC_PC)) begin
        next_s.rdata = s.exc_pc;
      end else if (hit(sysreg_num_in, CSRS_IDX_EXC_ST)) begin
        next_s.rdata = s.exc_st;
      end else if (hit(sysreg_num_in, CSRS_IDX_NMI_PC)) begin
        next_s.rdata = s.nmi_pc;
      end else if (hit(sysreg_num_in, CSRS_IDX_NMI_ST)) begin
        next_s.rdata = s.nmi_st;
      end else if (hit(sysreg_num_in, CSRS_IDX_CAUSE)) begin
        next_s.rdata = s.cause;
      end else if (hit(sysreg_num_in, CSRS_IDX_PSW)) begin
        next_s.rdata = cur_psw;
      end else begin
        // Reserved numbers read as zero
        next_s.rdata = CSRS_ZERO;
      end
    end
  end

  // State register; reset loads disabled interrupts
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= CSRS_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign rdata_out      = s.rdata;
  assign nmi_ack_out    = s.nmi_ack;
  assign exc_ack_out    = s.exc_ack;
  assign mi_ack_out     = s.mi_ack;
  assign sat_result_out = s.sat_result;
  assign sat_valid_out  = s.sat_valid;
  // Bit layout fixed by the flag position constants
  assign psw_out        = psw_word(s.flags);

endmodule

// ---- verification/csrs_req_model.sv ----
// Requester model: pipeline and interrupt logic raising level requests
`timescale 1ns/1ps

module csrs_req_model (
  input  wire logic       clk_in,  // CPU clock
  input  wire logic       rst_in,  // Sync reset
  input  wire logic [2:0] go_in,   // Start request: nmi, exc, mi
  input  wire logic [2:0] ack_in,  // Acks in the same order
  output logic      [2:0] req_out  // Level requests
);
  logic [2:0] pend;  // Requests still waiting

  // Drop at once on ack, else an exception is taken a second time
  assign req_out = pend & ~ack_in;

  // Hold each request until acknowledged, however long it is masked
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pend <= 3'h0;
    end else begin
      pend <= (pend | go_in) & ~ack_in;
    end
  end
endmodule

// ---- verification/csrs_regs_sva.sv ----
// Port assertions for the CPU system register set
`timescale 1ns/1ps

module csrs_regs_sva (
  input wire logic        clk_in,         // CPU clock
  input wire logic        rst_in,         // Sync reset
  input wire logic [4:0]  sysreg_num_in,  // Reg number
  input wire logic        load_system_register_instr_in,  // Write
  input wire logic        store_system_register_instr_in, // Read
  input wire logic [31:0] rdata_out,      // Read data
  input wire logic        nmi_req_in,     // NMI request
  input wire logic        exc_req_in,     // Exception request
  input wire logic        mi_req_in,      // Maskable request
  input wire logic        nmi_ack_out,    // NMI ack
  input wire logic        exc_ack_out,    // Exception ack
  input wire logic        mi_ack_out,     // Maskable ack
  input wire logic        flags_we_in,    // Flag update
  input wire logic [31:0] alu_result_in,  // ALU result
  input wire logic        alu_carry_in,   // Carry in
  input wire logic        alu_ovf_in,     // Overflow in
  input wire logic        sat_op_in,      // Sat op
  input wire logic [31:0] sat_result_out, // Sat result
  input wire logic        sat_valid_out,  // Sat pulse
  input wire logic [31:0] psw_out         // Status word
);
  import csrs_pkg::*;
  logic psw_wr;  // Software write to the status word

  // A status write may override arithmetic flags, so exclude it
  assign psw_wr = load_system_register_instr_in
                  && (sysreg_num_in == CSRS_IDX_PSW);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_psw_upper: assert property (psw_out[31:8] == 24'h0)
    else $error("status upper bits not zero");
  chk_psw_reset: assert property ($past(rst_in) |->
    psw_out == 32'h0000_0020) else $error("status reset value wrong");
  chk_nmi_take: assert property (nmi_req_in && !psw_out[7]
    |=> nmi_ack_out && psw_out[7]) else $error("NMI not taken");
  chk_nmi_blocks_nest: assert property (psw_out[7]
    |=> !mi_ack_out && !nmi_ack_out) else $error("nested ack");
  chk_id_blocks: assert property (psw_out[5] |=> !mi_ack_out)
    else $error("masked interrupt taken");
  chk_mi_sets_id: assert property (mi_ack_out |-> psw_out[5])
    else $error("disable flag not set");
  chk_exc_sets_flag: assert property (exc_ack_out |-> psw_out[6])
    else $error("exception flag not set");
  chk_exc_no_block: assert property (
    mi_req_in && psw_out[6:5] == 2'h2
    && !psw_out[7] && !nmi_req_in && !exc_req_in |=> mi_ack_out)
    else $error("interrupt blocked by exception flag");
  chk_sat_sticky: assert property (psw_out[4] && !psw_wr
    |=> psw_out[4]) else $error("saturation flag lost");
  chk_alu_carry_ovf: assert property (
    flags_we_in && !sat_op_in && !psw_wr
    |=> psw_out[3:2] == {$past(alu_carry_in), $past(alu_ovf_in)})
    else $error("carry or overflow flag wrong");
  chk_alu_s_z: assert property (
    flags_we_in && !sat_op_in && !psw_wr
    |=> psw_out[1:0] == {$past(alu_result_in[31]),
    $past(alu_result_in) == 32'h0}) else $error("sign or zero flag wrong");
  // A same-cycle status write may hold overflow without a clamp
  chk_sat_clamp: assert property (
    sat_valid_out && psw_out[2] && !$past(psw_wr)
    |-> psw_out[4] && sat_result_out == (psw_out[1] ? CSRS_SAT_MIN
    : CSRS_SAT_MAX)) else $error("saturated result wrong");
  chk_rsvd_read: assert property (store_system_register_instr_in
    && sysreg_num_in > 5'h05 |=> rdata_out == 32'h0)
    else $error("reserved register not zero");

  cov_mi: cover property (mi_ack_out && psw_out[6]);
  cov_nmi: cover property (nmi_ack_out);
  cov_clamp: cover property (sat_valid_out && psw_out[2]);
endmodule

bind csrs_regs csrs_regs_sva csrs_regs_sva_i (.clk_in, .rst_in,
  .sysreg_num_in, .load_system_register_instr_in,
  .store_system_register_instr_in, .rdata_out, .nmi_req_in, .exc_req_in,
  .mi_req_in, .nmi_ack_out, .exc_ack_out, .mi_ack_out, .flags_we_in,
  .alu_result_in, .alu_carry_in, .alu_ovf_in, .sat_op_in,
  .sat_result_out, .sat_valid_out, .psw_out);

// ---- verification/csrs_regs_test.sv ----
// Directed bench for the CPU system register set
`timescale 1ns/1ps

module csrs_regs_test;
  import csrs_pkg::*;
  logic        clk_in = 1'b0, rst_in = 1'b1;  // Clock, reset
  logic [4:0]  sysreg_num_in = 5'h00;         // Register number
  logic        load_system_register_instr_in = 1'b0;  // Write strobe
  logic        store_system_register_instr_in = 1'b0; // Read strobe
  logic [31:0] wdata_in = '0, pc_in = '0, rdata_out, psw_out;
  logic [15:0] nmi_code_in = '0, exc_code_in = '0, mi_code_in = '0;
  logic [2:0]  go = 3'h0, req, ack;           // Order: nmi, exc, mi
  logic        nmi_ack_out, exc_ack_out, mi_ack_out, sat_valid_out;
  logic        flags_we_in = 1'b0, alu_carry_in = 1'b0, alu_ovf_in = 1'b0;
  logic        sat_op_in = 1'b0, sat_sub_in = 1'b0;  // Sat controls
  logic [31:0] alu_result_in = '0, sat_a_in = '0, sat_b_in = '0;
  logic [31:0] sat_result_out;                // Sat result
  int          err_total = 0, checks_done = 0;  // Tallies

  assign ack = {nmi_ack_out, exc_ack_out, mi_ack_out};
  always #25 clk_in = ~clk_in;

  csrs_regs csrs_regs_i (.clk_in, .rst_in, .pc_in, .sysreg_num_in,
    .load_system_register_instr_in, .store_system_register_instr_in,
    .wdata_in, .rdata_out, .nmi_req_in(req[2]), .exc_req_in(req[1]),
    .mi_req_in(req[0]), .nmi_code_in, .exc_code_in, .mi_code_in,
    .nmi_ack_out, .exc_ack_out, .mi_ack_out, .flags_we_in, .alu_result_in,
    .alu_carry_in, .alu_ovf_in, .sat_op_in, .sat_sub_in, .sat_a_in,
    .sat_b_in, .sat_result_out, .sat_valid_out, .psw_out);
  csrs_req_model csrs_req_model_i (.clk_in, .rst_in, .go_in(go),
    .ack_in(ack), .req_out(req));

  // Verdict and end of run, shared with the watchdog
  task automatic complete_run();
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Word comparison
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Single-bit comparison, reported as a word
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask

  // Load-system-register (write) strobe for one cycle
  task automatic wr(input logic [4:0] n, input logic [31:0] d);
    @(negedge clk_in);
    sysreg_num_in = n;
    wdata_in = d;
    load_system_register_instr_in = 1'b1;
    @(negedge clk_in);
    load_system_register_instr_in = 1'b0;
  endtask

  // Read strobe; data stands on rdata_out the cycle after
  task automatic rd(input logic [4:0] n, input logic [31:0] exp);
    @(negedge clk_in);
    sysreg_num_in = n;
    store_system_register_instr_in = 1'b1;
    @(negedge clk_in);
    store_system_register_instr_in = 1'b0;
    cmp_word(rdata_out, exp);
  endtask

  // Ack is a one-cycle pulse, so look at every cycle of the window
  task automatic wait_ack(input int k, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      @(negedge clk_in);
      seen = seen | (ack[k] === 1'b1);
    end
    cmp_bit(seen, exp);
  endtask

  // Pulse the model's start line, then watch for the ack
  task automatic raise(input int k, input logic exp);
    @(negedge clk_in);
    go[k] = 1'b1;
    @(negedge clk_in);
    go[k] = 1'b0;
    wait_ack(k, exp);
  endtask

  // Ordinary flag update, then check the whole status word
  task automatic alu(input logic [31:0] r, input logic c, input logic o,
                     input logic [31:0] exp);
    @(negedge clk_in);
    {alu_result_in, alu_carry_in, alu_ovf_in, flags_we_in} = {r, c, o, 1'b1};
    @(negedge clk_in);
    flags_we_in = 1'b0;
    cmp_word(psw_out, exp);
  endtask

  // Saturating operation: result, pulse and flags
  task automatic sat(input logic [31:0] a, input logic [31:0] b,
                     input logic s, input logic [31:0] r,
                     input logic [31:0] p);
    @(negedge clk_in);
    {sat_a_in, sat_b_in, sat_sub_in, sat_op_in} = {a, b, s, 1'b1};
    @(negedge clk_in);
    sat_op_in = 1'b0;
    cmp_word(sat_result_out, r);
    cmp_word(psw_out, p);
    cmp_bit(sat_valid_out, 1'b1);
    // Pulse must drop while the result stays put
    @(negedge clk_in);
    cmp_bit(sat_valid_out, 1'b0);
    cmp_word(sat_result_out, r);
  endtask

  initial begin
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    rd(CSRS_IDX_PSW, CSRS_PSW_RESET);
    for (int i = 0; i < 5; i++) begin
      wr(5'(i), 32'h5a00_0000 + 32'(i));
      rd(5'(i), 32'h5a00_0000 + 32'(i));
    end
    // Reserved numbers 6 and 31 swallow writes
    for (int i = 6; i < 32; i += 25) begin
      wr(5'(i), 32'hffff_ffff);
      rd(5'(i), 32'h0);
    end
    wr(CSRS_IDX_PSW, 32'hffff_ffff);
    rd(CSRS_IDX_PSW, 32'h0000_00ff);
    wr(CSRS_IDX_PSW, 32'h0);
    cmp_word(psw_out, 32'h0);
    {pc_in, mi_code_in} = {32'h0000_1234, 16'h0090};
    raise(0, 1'b1);
    cmp_word(psw_out, 32'h0000_0020);
    rd(CSRS_IDX_EXC_PC, 32'h0000_1234);
    rd(CSRS_IDX_EXC_ST, 32'h0);
    rd(CSRS_IDX_CAUSE, 32'h5a00_0090);
    raise(0, 1'b0);
    wr(CSRS_IDX_PSW, 32'h0);
    wait_ack(0, 1'b1);
    wr(CSRS_IDX_PSW, 32'h0);
    {pc_in, exc_code_in} = {32'h0000_2000, 16'h0060};
    raise(1, 1'b1);
    cmp_word(psw_out, 32'h0000_0040);
    rd(CSRS_IDX_CAUSE, 32'h5a00_0060);
    rd(CSRS_IDX_EXC_PC, 32'h0000_2000);
    raise(0, 1'b1);
    rd(CSRS_IDX_EXC_ST, 32'h0000_0040);
    {pc_in, nmi_code_in} = {32'h0000_3000, 16'h0010};
    raise(2, 1'b1);
    cmp_word(psw_out, 32'h0000_00e0);
    rd(CSRS_IDX_NMI_PC, 32'h0000_3000);
    rd(CSRS_IDX_NMI_ST, 32'h0000_0060);
    rd(CSRS_IDX_CAUSE, 32'h0010_0090);
    wr(CSRS_IDX_PSW, 32'h0000_0080);
    raise(0, 1'b0);
    wr(CSRS_IDX_PSW, 32'h0);
    wait_ack(0, 1'b1);
    wr(CSRS_IDX_PSW, 32'h0);
    alu(32'h0, 1'b0, 1'b0, 32'h0000_0001);
    alu(32'h8000_0000, 1'b1, 1'b0, 32'h0000_000a);
    alu(32'h0000_0005, 1'b0, 1'b1, 32'h0000_0004);
    sat(32'h7fff_ffff, 32'h1, 1'b0, CSRS_SAT_MAX, 32'h14);
    sat(32'h8000_0000, 32'h1, 1'b1, CSRS_SAT_MIN, 32'h16);
    sat(32'h1, 32'h1, 1'b0, 32'h2, 32'h10);
    sat(32'h1, 32'h2, 1'b1, 32'hffff_ffff, 32'h1a);
    alu(32'h0, 1'b0, 1'b0, 32'h0000_0011);
    wr(CSRS_IDX_PSW, 32'h0);
    cmp_word(psw_out, 32'h0);
    complete_run();
  end

  // Whole run is about 150 cycles; far beyond that is a hang
  initial begin
    repeat (3000) @(posedge clk_in);
    err_total++;
    complete_run();
  end
endmodule
